// [design/fsq_pkg.sv]
/*
 * Package for the flash erase/suspend host controller: register map,
 * field positions, command bytes, pin bundle and timing counts.
 * Assumes a 25 MHz system clock and an 8-bit wide flash data bus.
 */
// Functional notes
// R1: Device drops commands during erase except suspend/reset.
// R2: Reads during block erase return status word.
// R3: Erase error holds status until read/reset; host and model clear it only on a reset, not on a read.
// R4: Erased unprotected blocks read all ones.
// R5: Suspend is one write, halts within 15us.
// R6: Early suspend immediate; no blocks after resume.
// R7: Suspended: other blocks normal, erasing give status.
// R8: Auto select in suspend; reset returns to suspend.
// R9: Only resume restarts; suspend repeatable.
// R10: Any read during program/erase gives status.
// R11: Polling bit inverts programmed bit seven.
// R12: Polling bit reads zero during erase.
// R13: Polling bit reads one once suspended.
// R14: Toggle bit inverts on every status read.
// R15: Toggle bit stops once suspended.
// R16: Error bit set on failure; host resets first.
// R17: Programming zero to one stays zero.
// R18: Erase timer bit zero until erasing starts.
// R19: Alternate toggle inverts only in erasing blocks.
// R20: Alternate toggle keeps inverting while suspended.
// R21: After erase error alternate toggle marks bad blocks.
// R22: Host ignores undefined status bits.
// R23: Host adds blocks within 50us of previous.
// R24: Ready/busy low while busy, high when suspended.
package fsq_pkg;
    localparam int CLK_MHZ = 25;
    localparam int T_ACCESS_NS = 45;
    localparam int T_SUSPEND_NS = 15000;
    localparam int T_ADD_WINDOW_NS = 50000;
    localparam int CYC_STROBE = (T_ACCESS_NS * CLK_MHZ + 999) / 1000 + 1;
    localparam int CYC_SUSPEND = (T_SUSPEND_NS * CLK_MHZ) / 1000;
    localparam int CYC_WINDOW = (T_ADD_WINDOW_NS * CLK_MHZ) / 1000;
    localparam int CNT_W = 12;

    localparam int ADDR_W = 19;
    localparam int DATA_W = 8;

    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_ADDR = 5'h04;
    localparam logic [4:0] REG_WDATA = 5'h08;
    localparam logic [4:0] REG_STAT = 5'h0C;
    localparam logic [4:0] REG_RDATA = 5'h10;

    localparam int CTRL_OP_LSB = 0;
    localparam int CTRL_RST_PIN = 8;
    localparam logic [8:0] CTRL_RESET = 9'h100;

    localparam int ST_BUSY = 0;
    localparam int ST_OK = 1;
    localparam int ST_ERROR = 2;
    localparam int ST_SUSP = 3;
    localparam int ST_REFUSED = 4;
    localparam int ST_TIMEOUT = 5;
    localparam int ST_WINDOW = 6;
    localparam int ST_RDY = 7;

    localparam int DQ_POLL = 7;
    localparam int DQ_TOGGLE = 6;
    localparam int DQ_ERROR = 5;
    localparam int DQ_TIMER = 3;
    localparam int DQ_ALT = 2;
    localparam logic [7:0] DQ_DEFINED = 8'hEC;

    localparam logic [7:0] CMD_SUSPEND = 8'hB0;
    localparam logic [7:0] CMD_RESUME = 8'h30;
    localparam logic [7:0] CMD_BLOCK = 8'h30;
    localparam logic [7:0] CMD_RESET = 8'hF0;

    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_WRITE = 4'h1,
        OP_READ = 4'h2,
        OP_POLL = 4'h3,
        OP_SUSPEND = 4'h4,
        OP_RESUME = 4'h5,
        OP_RESET = 4'h6,
        OP_BLOCK_FIRST = 4'h7,
        OP_BLOCK_ADD = 4'h8
    } fsq_op_e;

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq_out;
        logic dq_oe;
    } fsq_pins_s;

    typedef struct packed {
        logic is_wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } fsq_cyc_s;
endpackage

// [design/fsq_buscyc.sv]
/*
 * One asynchronous flash bus cycle, read or write, timed in clocks.
 * Assumes the flash data lines are sampled synchronously to clk.
 */
`timescale 1ns/100ps
module fsq_buscyc (
    input wire logic clk,
    input wire logic resetn,
    input wire logic req,
    input wire fsq_pkg::fsq_cyc_s cyc,
    input wire logic [fsq_pkg::DATA_W-1:0] dq_in,
    output fsq_pkg::fsq_pins_s pins,
    output logic done,
    output logic [fsq_pkg::DATA_W-1:0] rdata
);
    import fsq_pkg::*;

    typedef enum logic [1:0] {
        CY_IDLE = 2'b00,
        CY_STROBE = 2'b01,
        CY_RECOVER = 2'b10
    } fsq_cy_e;

    localparam logic [3:0] STROBE_LAST = 4'(CYC_STROBE - 1);

    fsq_cy_e state_q;
    logic [3:0] cnt_q;
    wire start = (state_q == CY_IDLE) && req && !done;
    wire strobe_end = (state_q == CY_STROBE) && (cnt_q == STROBE_LAST);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= CY_IDLE;
            cnt_q <= 4'h0;
            pins <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, dq_out: '0, dq_oe: 1'b0};
            done <= 1'b0;
            rdata <= 8'h00;
        end else begin
            done <= 1'b0;
            unique case (state_q)
                CY_IDLE: begin
                    if (start) begin
                        state_q <= CY_STROBE;
                        cnt_q <= 4'h0;
                        pins.addr <= cyc.addr;
                        pins.dq_out <= cyc.wdata;
                        pins.dq_oe <= cyc.is_wr;
                        pins.ce_n <= 1'b0;
                        pins.oe_n <= cyc.is_wr;
                        pins.we_n <= !cyc.is_wr;
                    end
                end
                CY_STROBE: begin
                    cnt_q <= cnt_q + 4'h1;
                    if (strobe_end) begin
                        state_q <= CY_RECOVER;
                        rdata <= dq_in;
                        pins.ce_n <= 1'b1;
                        pins.oe_n <= 1'b1;
                        pins.we_n <= 1'b1;
                    end
                end
                CY_RECOVER: begin
                    // Data held one cycle past the rising strobe for hold time
                    pins.dq_oe <= 1'b0;
                    state_q <= CY_IDLE;
                    done <= 1'b1;
                end
            endcase
        end
    end
endmodule

// [design/fsq_host.sv]
/*
 * Host controller for a parallel flash program/erase engine: Wishbone
 * registers, erase suspend/resume, toggle polling and block-add window.
 * Assumes a classic Wishbone master on clk and the flash pins synchronous.
 */
// The implementer's own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/100ps
module fsq_host (
    input wire logic clk,
    input wire logic resetn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic flash_rst_n,
    output logic [fsq_pkg::ADDR_W-1:0] flash_addr,
    output logic [fsq_pkg::DATA_W-1:0] flash_dq_o,
    output logic flash_dq_oe,
    input wire logic [fsq_pkg::DATA_W-1:0] flash_dq_i,
    input wire logic ready_busy_out
);
    import fsq_pkg::*;

    typedef enum logic [2:0] {
        M_IDLE = 3'b000,
        M_WRITE = 3'b001,
        M_READ = 3'b010,
        M_POLL1 = 3'b011,
        M_POLL2 = 3'b100,
        M_POLL3 = 3'b101,
        M_POLL4 = 3'b110
    } fsq_main_e;

    fsq_main_e state_q;
    fsq_op_e op_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] wdata_q;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] prev_q;
    logic [DATA_W-1:0] last_status_q;
    logic rst_pin_q;
    logic ok_q, err_q, susp_q, refused_q, timeout_q, rdy_q;
    logic win_open_q;
    logic [CNT_W-1:0] win_cnt_q;
    logic [CNT_W-1:0] susp_cnt_q;
    logic req_q;
    logic ack_q;
    logic [31:0] dat_q;
    fsq_cyc_s cyc_q;
    fsq_pins_s pins;
    logic cyc_done;
    logic [DATA_W-1:0] cyc_rdata;

    fsq_buscyc u_cyc (
        .clk(clk),
        .resetn(resetn),
        .req(req_q),
        .cyc(cyc_q),
        .dq_in(flash_dq_i),
        .pins(pins),
        .done(cyc_done),
        .rdata(cyc_rdata)
    );

    assign flash_ce_n = pins.ce_n;
    assign flash_oe_n = pins.oe_n;
    assign flash_we_n = pins.we_n;
    assign flash_addr = pins.addr;
    assign flash_dq_o = pins.dq_out;
    assign flash_dq_oe = pins.dq_oe;
    assign flash_rst_n = rst_pin_q;

    // Bus decode; register writes land on the acknowledging edge
    wire bus_req = wb_cyc_i && wb_stb_i;
    wire bus_wr = bus_req && wb_we_i && ack_q;
    wire wr_ctrl = bus_wr && (wb_adr_i == REG_CTRL) && wb_sel_i[0];
    wire wr_addr = bus_wr && (wb_adr_i == REG_ADDR);
    wire wr_wdata = bus_wr && (wb_adr_i == REG_WDATA) && wb_sel_i[0];
    wire [3:0] op_field = wb_dat_i[CTRL_OP_LSB +: 4];
    wire busy = (state_q != M_IDLE);
    wire [DATA_W-1:0] masked = cyc_rdata & DQ_DEFINED;
    wire [7:0] stat_word = {rdy_q, win_open_q, timeout_q, refused_q,
                            susp_q, err_q, ok_q, busy};

    // R16: only a reset is accepted while an error stands
    wire err_block = err_q && (op_field != OP_RESET);
    // R23: extra blocks only inside the open window
    wire win_block = (op_field == OP_BLOCK_ADD) && !win_open_q;
    wire op_valid = (op_field >= OP_WRITE) && (op_field <= OP_BLOCK_ADD);
    wire launch = wr_ctrl && !busy && op_valid && !err_block && !win_block;
    wire refuse = wr_ctrl && op_valid && !launch;

    wire toggle_same = (cyc_rdata[DQ_TOGGLE] == prev_q[DQ_TOGGLE]);
    wire susp_expired = (susp_cnt_q >= CNT_W'(CYC_SUSPEND));
    wire win_expired = (win_cnt_q >= CNT_W'(CYC_WINDOW - 1));
    wire poll_done = cyc_done && (state_q == M_POLL2);
    wire fail_done = cyc_done && (state_q == M_POLL4);

    wire [ADDR_W-1:0] wb_addr_val = wb_dat_i[ADDR_W-1:0];
    wire [31:0] rd_mux = (wb_adr_i == REG_CTRL) ? {23'h0, rst_pin_q, 4'h0, op_q} :
                         (wb_adr_i == REG_ADDR) ? {13'h0, addr_q} :
                         (wb_adr_i == REG_WDATA) ? {24'h0, wdata_q} :
                         (wb_adr_i == REG_STAT) ? {16'h0, last_status_q, stat_word} :
                         (wb_adr_i == REG_RDATA) ? {24'h0, rdata_q} : 32'h0;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0;
        end else begin
            ack_q <= bus_req && !ack_q;
            dat_q <= rd_mux;
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            addr_q <= '0;
            wdata_q <= 8'h00;
            rst_pin_q <= CTRL_RESET[CTRL_RST_PIN];
        end else begin
            if (wr_addr) begin
                addr_q <= wb_addr_val;
            end
            if (wr_wdata) begin
                wdata_q <= wb_dat_i[DATA_W-1:0];
            end
            if (wr_ctrl) begin
                rst_pin_q <= wb_dat_i[CTRL_RST_PIN];
            end
        end
    end

    // Cycle request: command byte chosen from the operation
    function automatic fsq_cyc_s first_cycle(input fsq_op_e op, input logic [ADDR_W-1:0] a,
                                            input logic [DATA_W-1:0] d);
        fsq_cyc_s c;
        c.addr = a;
        c.is_wr = 1'b1;
        c.wdata = d;
        unique case (op)
            OP_READ, OP_POLL: c.is_wr = 1'b0;
            OP_SUSPEND: c.wdata = CMD_SUSPEND;
            OP_RESUME: c.wdata = CMD_RESUME;
            OP_RESET: c.wdata = CMD_RESET;
            OP_BLOCK_FIRST, OP_BLOCK_ADD: c.wdata = CMD_BLOCK;
            default: c.wdata = d;
        endcase
        return c;
    endfunction

    wire fsq_op_e new_op = fsq_op_e'(op_field);
    wire fsq_cyc_s launch_cyc = first_cycle(new_op, addr_q, wdata_q);
    wire launch_rd = !launch_cyc.is_wr;
    wire need_poll = (op_q == OP_SUSPEND);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= M_IDLE;
            op_q <= OP_NONE;
            req_q <= 1'b0;
            cyc_q <= '0;
            rdata_q <= 8'h00;
            prev_q <= 8'h00;
            last_status_q <= 8'h00;
            ok_q <= 1'b0;
            err_q <= 1'b0;
            susp_q <= 1'b0;
            refused_q <= 1'b0;
            timeout_q <= 1'b0;
            susp_cnt_q <= '0;
        end else begin
            if (cyc_done) begin
                req_q <= 1'b0;
            end
            if (refuse) begin
                refused_q <= 1'b1;
            end
            if (state_q == M_POLL1 || state_q == M_POLL2) begin
                susp_cnt_q <= susp_cnt_q + CNT_W'(1);
            end
            unique case (state_q)
                M_IDLE: begin
                    if (launch) begin
                        op_q <= new_op;
                        cyc_q <= launch_cyc;
                        req_q <= 1'b1;
                        ok_q <= 1'b0;
                        refused_q <= 1'b0;
                        timeout_q <= 1'b0;
                        susp_cnt_q <= '0;
                        state_q <= launch_rd ? ((new_op == OP_POLL) ? M_POLL1 : M_READ)
                                             : M_WRITE;
                    end
                end
                M_READ: begin
                    if (cyc_done) begin
                        rdata_q <= cyc_rdata;
                        ok_q <= 1'b1;
                        state_q <= M_IDLE;
                    end
                end
                M_WRITE: begin
                    if (cyc_done) begin
                        // R3: only a reset clears the stored error; reads are refused while it stands
                        if (op_q == OP_RESET) begin
                            err_q <= 1'b0;
                        end
                        // R9: resume is the only restart of a suspended erase
                        if (op_q == OP_RESUME) begin
                            susp_q <= 1'b0;
                        end
                        cyc_q.is_wr <= 1'b0;
                        req_q <= need_poll;
                        ok_q <= !need_poll;
                        // R5: after the suspend write, poll for the halt
                        state_q <= need_poll ? M_POLL1 : M_IDLE;
                    end
                end
                M_POLL1, M_POLL3: begin
                    if (cyc_done) begin
                        prev_q <= cyc_rdata;
                        req_q <= 1'b1;
                        state_q <= (state_q == M_POLL1) ? M_POLL2 : M_POLL4;
                    end
                end
                M_POLL2: begin
                    if (poll_done) begin
                        // R22: undefined status bits are dropped
                        last_status_q <= masked;
                        rdata_q <= cyc_rdata;
                        // R14: toggle stopped means the engine is quiet
                        if (toggle_same) begin
                            ok_q <= 1'b1;
                            // R15: stopped toggle marks the suspend complete
                            if (op_q == OP_SUSPEND) begin
                                susp_q <= 1'b1;
                            end
                            state_q <= M_IDLE;
                        // R16: error bit seen, confirm with two reads
                        end else if (cyc_rdata[DQ_ERROR]) begin
                            req_q <= 1'b1;
                            state_q <= M_POLL3;
                        // R5: suspend not honoured within its bound
                        end else if (op_q == OP_SUSPEND && susp_expired) begin
                            timeout_q <= 1'b1;
                            state_q <= M_IDLE;
                        end else begin
                            req_q <= 1'b1;
                            state_q <= M_POLL1;
                        end
                    end
                end
                M_POLL4: begin
                    if (fail_done) begin
                        last_status_q <= masked;
                        rdata_q <= cyc_rdata;
                        // R3: still toggling after error means a failed operation
                        err_q <= !toggle_same;
                        ok_q <= toggle_same;
                        state_q <= M_IDLE;
                    end
                end
                default: state_q <= M_IDLE;
            endcase
        end
    end

    // R23: block-add window, restarted by each selected block
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            win_open_q <= 1'b0;
            win_cnt_q <= '0;
        end else if (launch && (new_op == OP_BLOCK_FIRST || new_op == OP_BLOCK_ADD)) begin
            win_open_q <= 1'b1;
            win_cnt_q <= '0;
        // R6: no additions once suspended or resumed
        end else if (launch && (new_op == OP_SUSPEND || new_op == OP_RESUME)) begin
            win_open_q <= 1'b0;
        // R18: timer bit at one means erasing has begun
        end else if (poll_done && cyc_rdata[DQ_TIMER]) begin
            win_open_q <= 1'b0;
        end else if (win_open_q) begin
            win_cnt_q <= win_cnt_q + CNT_W'(1);
            if (win_expired) begin
                win_open_q <= 1'b0;
            end
        end
    end

    // R24: ready/busy level kept for software
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdy_q <= 1'b0;
        end else begin
            rdy_q <= ready_busy_out;
        end
    end
endmodule

// [verif/fsq_host_asserts.sv]
/* Checker for the fsq_host pins and Wishbone handshake.
   Assumes one clock domain and the asynchronous low reset. */
`timescale 1ns/100ps
module fsq_host_asserts (
    input wire logic clk,
    input wire logic resetn,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic flash_ce_n,
    input wire logic flash_oe_n,
    input wire logic flash_we_n,
    input wire logic flash_rst_n,
    input wire logic [fsq_pkg::ADDR_W-1:0] flash_addr,
    input wire logic [fsq_pkg::DATA_W-1:0] flash_dq_o,
    input wire logic flash_dq_oe
);
    import fsq_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_latency_a: assert property ($rose(wb_stb_i) |=> wb_ack_o)
        else $error("ack late");
    bus_clash_a: assert property (!flash_oe_n |-> !flash_dq_oe && flash_we_n)
        else $error("host drives dq during read");
    chip_sel_a: assert property (!flash_oe_n || !flash_we_n |-> !flash_ce_n)
        else $error("strobe without chip enable");
    read_width_a: assert property ($fell(flash_oe_n) |-> !flash_oe_n[*3] ##1 flash_oe_n)
        else $error("read strobe width");
    write_width_a: assert property ($fell(flash_we_n) |-> !flash_we_n[*3] ##1 flash_we_n)
        else $error("write strobe width");
    write_hold_a: assert property (!flash_we_n && !$past(flash_we_n) |->
        $stable(flash_dq_o) && $stable(flash_addr) && flash_dq_oe)
        else $error("write data moved");
    reset_pin_a: assert property (wb_ack_o && wb_we_i && wb_adr_i == REG_CTRL && wb_sel_i[0]
        |=> flash_rst_n == $past(wb_dat_i[8]))
        else $error("reset pin not following control");
endmodule
bind fsq_host fsq_host_asserts u_fsq_host_asserts (.clk(clk), .resetn(resetn),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_rst_n(flash_rst_n),
    .flash_addr(flash_addr), .flash_dq_o(flash_dq_o), .flash_dq_oe(flash_dq_oe));

// [verif/fsq_flash_model.sv]
/* Flash device model: block erase, suspend, resume, status word.
   Sees the host pins; device time is counted in host clocks. */
`timescale 1ns/100ps
module fsq_flash_model #(
    parameter int WIN = 1250,
    parameter int ERASE = 600,
    parameter int SUSP = 100,
    parameter int PROG = 120
) (
    input wire logic clk,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic rst_n,
    input wire logic [18:0] addr,
    input wire logic [7:0] din,
    input wire logic fail,
    output logic [7:0] dout,
    output logic rdy
);
    logic [7:0] mem_q [0:255];
    logic [7:0] eblk_q = 8'h00, last_q = 8'h00, pd_q, d_q;
    logic [2:0] mode_q = 3'h0, ret_q;
    logic tog_q = 1'b0, alt_q = 1'b0, we_q = 1'b1, oe_q = 1'b1;
    logic [18:0] a_q, pa_q;
    int cnt_q = 0, ecnt_q = 0;
    wire hit = eblk_q[addr[18:16]];
    wire show = (mode_q != 3'h0 && mode_q != 3'h4) || (mode_q == 3'h4 && hit);
    wire [7:0] stat = {mode_q == 3'h4 || (mode_q == 3'h5 && !pd_q[7]), tog_q, mode_q == 3'h6,
        1'b1, mode_q == 3'h2 || mode_q == 3'h3 || mode_q == 3'h6, alt_q, 2'b11};
    assign dout = (!ce_n && !oe_n) ? (show ? stat : mem_q[{addr[18:16], addr[4:0]}]) : ~last_q;
    assign rdy = mode_q == 3'h0 || mode_q == 3'h4;
    initial foreach (mem_q[i]) mem_q[i] = 8'hFF;
    always @(posedge clk) begin
        we_q <= we_n;
        oe_q <= oe_n;
        cnt_q <= cnt_q + 1;
        if (!we_n || !oe_n) a_q <= addr;
        if (!we_n) d_q <= din;
        if (!ce_n && !oe_n) last_q <= dout;
        if (mode_q == 3'h2) ecnt_q <= ecnt_q + 1;
        if (mode_q == 3'h1 && cnt_q >= WIN) mode_q <= 3'h2;
        if (mode_q == 3'h3 && cnt_q >= SUSP) mode_q <= 3'h4;
        if (mode_q == 3'h5 && cnt_q >= PROG) begin
            mem_q[{pa_q[18:16], pa_q[4:0]}] <= mem_q[{pa_q[18:16], pa_q[4:0]}] & pd_q;
            mode_q <= ret_q;
        end
        if (mode_q == 3'h2 && ecnt_q >= ERASE) begin
            mode_q <= fail ? 3'h6 : 3'h0;
            for (int i = 0; i < 256; i++) if (eblk_q[i[7:5]] && !fail) mem_q[i] <= 8'hFF;
        end
        if (!oe_q && oe_n && show) begin
            tog_q <= tog_q ^ (mode_q != 3'h4);
            alt_q <= alt_q ^ eblk_q[a_q[18:16]];
        end
        if (!we_q && we_n) begin
            cnt_q <= 0;
            if (d_q == 8'hF0 && mode_q == 3'h6) mode_q <= 3'h0;
            else if (d_q == 8'hF0 && mode_q == 3'h7) mode_q <= 3'h4;
            else if (d_q == 8'h90 && mode_q == 3'h4) mode_q <= 3'h7;
            else if (d_q == 8'hB0 && mode_q == 3'h1) mode_q <= 3'h4;
            else if (d_q == 8'hB0 && mode_q == 3'h2) mode_q <= 3'h3;
            else if (d_q == 8'h30 && mode_q == 3'h4) mode_q <= 3'h2;
            else if (d_q == 8'h30 && mode_q <= 3'h1) begin
                mode_q <= 3'h1;
                eblk_q <= (mode_q == 3'h1 ? eblk_q : 8'h00) | (8'h01 << a_q[18:16]);
                ecnt_q <= 0;
            end else if (mode_q == 3'h0 || (mode_q == 3'h4 && !eblk_q[a_q[18:16]])) begin
                mode_q <= 3'h5;
                ret_q <= mode_q;
                pd_q <= d_q;
                pa_q <= a_q;
            end
        end
        if (!rst_n) mode_q <= 3'h0;
    end
endmodule

// [verif/fsq_host_tb.sv]
/* Self-checking bench for fsq_host with the flash model on its pins.
   Classic Wishbone tasks; 25 MHz clock, reset held 6 cycles. */
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module fsq_host_tb;
    import fsq_pkg::*;
    logic clk = 1'b0, resetn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, fail = 1'b0;
    logic [4:0] adr = 5'h00;
    logic [31:0] wdat = 32'h0, rd, st, q1, q2, dat_o;
    logic [7:0] dqi, dqo;
    logic [18:0] fa;
    logic ack, ce_n, oe_n, we_n, rst_n, dq_oe, rdy;
    int bad_count = 0, checks_done = 0;
    always #20 clk = ~clk;
    fsq_host u_fsq_host (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
        .flash_rst_n(rst_n), .flash_addr(fa), .flash_dq_o(dqo), .flash_dq_oe(dq_oe),
        .flash_dq_i(dqi), .ready_busy_out(rdy));
    fsq_flash_model u_fsq_flash_model (.clk(clk), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .rst_n(rst_n), .addr(fa), .din(dqo), .fail(fail), .dout(dqi), .rdy(rdy));
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d,
            output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
        if (n >= 20) begin
            bad_count++;
            end_sim();
        end
    endtask
    // Runs one control op, waits idle, leaves STAT in st and RDATA in rd
    task automatic op(input fsq_op_e c, input logic [18:0] a, input logic [7:0] d);
        int n;
        n = 0;
        wb(1'b1, REG_ADDR, {13'h0, a}, rd);
        wb(1'b1, REG_WDATA, {24'h0, d}, rd);
        wb(1'b1, REG_CTRL, {23'h0, 1'b1, 4'h0, c}, rd);
        do begin
            wb(1'b0, REG_STAT, 32'h0, st);
            n++;
        end while (st[ST_BUSY] !== 1'b0 && n < 3000);
        if (n >= 3000) begin
            bad_count++;
            end_sim();
        end
        wb(1'b0, REG_RDATA, 32'h0, rd);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        wb(1'b0, REG_CTRL, 32'h0, rd);
        `CHK("rst bit", 1'b1, rd[CTRL_RST_PIN])
        wb(1'b1, 5'h14, 32'hFF, rd);
        wb(1'b0, 5'h14, 32'h0, rd);
        `CHK("unmapped", 32'h0, rd)
        wb(1'b1, REG_CTRL, 32'h0, rd);
        `CHK("rst pin", 1'b0, rst_n)
        wb(1'b1, REG_CTRL, 32'(CTRL_RESET), rd);
        op(OP_WRITE, 19'h00003, 8'h5A);
        op(OP_READ, 19'h00003, 8'h00);
        `CHK("poll bit", 1'b1, rd[7])
        op(OP_POLL, 19'h00003, 8'h00);
        `CHK("prog ok", 1'b1, st[ST_OK])
        op(OP_WRITE, 19'h00003, 8'hFF);
        op(OP_POLL, 19'h00003, 8'h00);
        op(OP_READ, 19'h00003, 8'h00);
        `CHK("no set", 8'h5A, rd[7:0])
        op(OP_BLOCK_FIRST, 19'h10000, 8'h00);
        `CHK("window", 1'b1, st[ST_WINDOW])
        op(OP_READ, 19'h10005, 8'h00);
        `CHK("pre-start", 8'h00, rd[7:0] & 8'h88)
        op(OP_SUSPEND, 19'h10005, 8'h00);
        `CHK("early susp", 2'b11, {st[ST_SUSP], st[ST_RDY]})
        op(OP_WRITE, 19'h10005, 8'h90);
        op(OP_RESET, 19'h10005, 8'h00);
        op(OP_READ, 19'h10005, 8'h00);
        q1 = rd;
        op(OP_READ, 19'h10005, 8'h00);
        `CHK("susp stat", 3'b101, {rd[7], rd[6] ^ q1[6], rd[2] ^ q1[2]})
        op(OP_READ, 19'h00003, 8'h00);
        `CHK("other blk", 8'h5A, rd[7:0])
        op(OP_RESUME, 19'h10005, 8'h00);
        op(OP_BLOCK_ADD, 19'h20000, 8'h00);
        `CHK("add refused", 1'b1, st[ST_REFUSED])
        op(OP_READ, 19'h10005, 8'h00);
        q1 = rd;
        op(OP_READ, 19'h00003, 8'h00);
        q2 = rd;
        op(OP_READ, 19'h10005, 8'h00);
        `CHK("erasing", 8'h08, q1[7:0] & 8'h88)
        `CHK("toggle", 2'b11, {q1[6] ^ q2[6], q2[6] ^ rd[6]})
        `CHK("alt", 2'b10, {q1[2] ^ q2[2], q2[2] ^ rd[2]})
        op(OP_SUSPEND, 19'h10005, 8'h00);
        `CHK("susp time", 2'b10, {st[ST_SUSP], st[ST_TIMEOUT]})
        op(OP_RESUME, 19'h10005, 8'h00);
        op(OP_POLL, 19'h10005, 8'h00);
        `CHK("erase ok", 1'b1, st[ST_OK])
        op(OP_READ, 19'h1001F, 8'h00);
        `CHK("erased", 8'hFF, rd[7:0])
        fail <= 1'b1;
        op(OP_BLOCK_FIRST, 19'h30000, 8'h00);
        op(OP_POLL, 19'h30000, 8'h00);
        `CHK("erase err", 2'b11, {st[ST_ERROR], st[8 + DQ_ERROR]})
        `CHK("undef bits", 3'b000, {st[12], st[9:8]})
        op(OP_READ, 19'h00003, 8'h00);
        `CHK("err refuse", 1'b1, st[ST_REFUSED])
        op(OP_RESET, 19'h00003, 8'h00);
        fail <= 1'b0;
        op(OP_READ, 19'h00003, 8'h00);
        `CHK("after reset", 9'h05A, {st[ST_ERROR], rd[7:0]})
        end_sim();
    end
endmodule
